// ### core/srdc_pkg.sv
package srdc_pkg;

	// ****************************************
	// command codes
	// ****************************************
	localparam logic [7:0] OP_RELEASE10 = 8'h57;
	localparam logic [7:0] OP_DEPOP     = 8'h9E;
	localparam logic [4:0] SA_DEPOP     = 5'h18;
	localparam logic [7:0] OP_DEVID     = 8'hA3;
	localparam logic [4:0] SA_DEVID     = 5'h05;
	localparam logic [7:0] STORAGE_ELEM_TYPE = 8'h01;

	// ****************************************
	// field positions (byte index, bit)
	// ****************************************
	localparam int REL_FLAG_BYTE    = 1;
	localparam int REL_THIRD_BIT    = 4;
	localparam int REL_EXT_BIT      = 0;
	localparam int SA_BYTE          = 1;
	localparam int CAP_FIRST_BYTE   = 2;
	localparam int ELEM_FIRST_BYTE  = 10;
	localparam int LUN_FIRST_BYTE   = 4;
	localparam int ALLOC_FIRST_BYTE = 6;
	localparam int CDB_BYTES        = 16;
	localparam int ID_HDR_BYTES     = 4;

	// ****************************************
	// status and sense codes
	// ****************************************
	localparam logic [7:0]  STATUS_GOOD      = 8'h00;
	localparam logic [7:0]  STATUS_CHECK     = 8'h02;
	localparam logic [3:0]  SK_NONE          = 4'h0;
	localparam logic [3:0]  SK_NOT_READY     = 4'h2;
	localparam logic [3:0]  SK_MEDIUM_ERROR  = 4'h3;
	localparam logic [3:0]  SK_ILLEGAL_REQ   = 4'h5;
	localparam logic [15:0] ASC_NONE         = 16'h0000;
	localparam logic [15:0] ASC_INVALID_CDB  = 16'h2400;
	localparam logic [15:0] ASC_UCODE_ACT    = 16'h0411;
	localparam logic [15:0] ASC_DEPOP_FAILED = 16'h3106;

	typedef logic [CDB_BYTES-1:0][7:0] srdc_cdb_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_WORK = 4'b0010,
		ST_DATA = 4'b0100,
		ST_DONE = 4'b1000
	} srdc_state_e;

	typedef struct packed {
		logic [7:0]  status;
		logic [3:0]  senseKey;
		logic [15:0] asc;
	} srdc_result_s;

endpackage : srdc_pkg

// ### core/srdc_cmds.sv
// Notes on behaviour
// - release from other initiator's reservation returns Good, reservation untouched.
// - nonzero third-party flag on release gives Check, Illegal Request, Invalid Field.
// - reservation identification byte of release is ignored.
// - opcode 9Eh, service action 18h requests element depopulation and capacity truncation.
// - requested capacity from bytes 2-9; zero lets the device choose.
// - unsettable capacity keeps capacity and gives Check, Illegal Request, Invalid Field.
// - unsupported or non-storage element id gives Check, Illegal Request, Invalid Field.
// - failed depopulate sets format corrupt; medium access fails until clean format; here reset also clears format corrupt.
// - pending deferred microcode rejects depopulate with Not Ready, activation required.
// - element without depopulation support gives Check, Illegal Request, Invalid Field.
// - opcode A3h, service action 05h returns stored device identifier data.
// - nonzero LUN in bytes 4-5 of report gives Check, Illegal Request.
// - allocation length bytes 6-9 truncates returned data without error.
// - data begins with 4-byte identifier length, untruncated, then identifier.
// - identifier length starts zero, changes only on successful set identifier.
// - stored identifier survives resets, power cycles and formats; here power-up clears it to zero length and zero bytes.
// - same identifier reported to every initiator on every port.
// - nonvolatile store not ready ends report at once with Not Ready.
`timescale 1ns/10ps
`default_nettype none

module srdc_cmds #(
	parameter int ID_MAX_BYTES = 64,
	parameter int ELEM_ID_W    = 32
) (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       reset,
	// command in
	input  wire logic                       cmdValid,
	output logic                            cmdReady,
	input  wire srdc_pkg::srdc_cdb_t        cdb,
	input  wire logic                       mediumAccessCmd,
	// reservation store
	input  wire logic                       reservedByOther,
	output logic                            releaseReq,
	// depopulation engine
	output logic                            depopStart,
	output logic [63:0]                     depopCapacity,
	output logic [ELEM_ID_W-1:0]            depopElement,
	input  wire logic                       depopDone,
	input  wire logic                       depopOk,
	input  wire logic                       depopCapUnsettable,
	input  wire logic                       elemSupported,
	input  wire logic [7:0]                 elemPhysType,
	input  wire logic                       elemDepopSupported,
	input  wire logic                       ucodeDeferred,
	input  wire logic                       formatDone,
	input  wire logic                       formatOk,
	output logic                            formatCorrupt,
	// identifier store
	input  wire logic                       nvReady,
	input  wire logic [3:0]                 nvSenseKey,
	input  wire logic [15:0]                nvAsc,
	input  wire logic                       setIdValid,
	input  wire logic [31:0]                setIdLength,
	input  wire logic [ID_MAX_BYTES*8-1:0]  setIdValue,
	// data in stream
	output logic                            dataValid,
	output logic [7:0]                      dataByte,
	output logic                            dataLast,
	input  wire logic                       dataReady,
	// completion
	output logic                            doneValid,
	output srdc_pkg::srdc_result_s          result
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		srdc_pkg::srdc_state_e       fsm;
		srdc_pkg::srdc_result_s      res;
		logic                        corrupt;
		logic                        relReq;
		logic                        dpStart;
		logic [63:0]                 cap;
		logic [ELEM_ID_W-1:0]        elem;
		logic [31:0]                 xferLen;
		logic [31:0]                 idx;
		logic                        dValid;
		logic [7:0]                  dByte;
		logic                        dLast;
	} srdc_regs_s;

	srdc_regs_s r;
	srdc_regs_s next_r;

	// identifier store is kept outside the reset domain so it survives resets and formats
	logic [31:0]                    idLength = 32'h0000_0000;
	wire  [ID_MAX_BYTES-1:0][7:0]   idBytes;

	logic [31:0]  allocLen;
	logic [31:0]  fullLen;
	logic [15:0]  lunField;
	logic [31:0]  nextIdx;

	function automatic logic [7:0] replyByte(input logic [31:0] i);
		logic [31:0] k;
		k = i - 32'(srdc_pkg::ID_HDR_BYTES);
		if (i < 32'(srdc_pkg::ID_HDR_BYTES))
			return idLength[8'(31 - 8*i) -: 8];
		else if (k < 32'(ID_MAX_BYTES))
			return idBytes[k];
		else
			return 8'h00;
	endfunction : replyByte

	always_comb begin
		allocLen = {cdb[srdc_pkg::ALLOC_FIRST_BYTE], cdb[srdc_pkg::ALLOC_FIRST_BYTE+1],
			cdb[srdc_pkg::ALLOC_FIRST_BYTE+2], cdb[srdc_pkg::ALLOC_FIRST_BYTE+3]};
		lunField = {cdb[srdc_pkg::LUN_FIRST_BYTE], cdb[srdc_pkg::LUN_FIRST_BYTE+1]};
		fullLen  = idLength + 32'(srdc_pkg::ID_HDR_BYTES);
		nextIdx  = r.idx + 32'h0000_0001;
	end

	// ****************************************
	// command decode
	// ****************************************
	logic         isRelease;
	logic         isDepop;
	logic         isDevid;
	logic         thirdParty;
	logic [63:0]  capField;
	logic [31:0]  elemField;

	always_comb begin
		isRelease  = (cdb[0] == srdc_pkg::OP_RELEASE10);
		isDepop    = (cdb[0] == srdc_pkg::OP_DEPOP) &&
			(cdb[srdc_pkg::SA_BYTE][4:0] == srdc_pkg::SA_DEPOP);
		isDevid    = (cdb[0] == srdc_pkg::OP_DEVID) &&
			(cdb[srdc_pkg::SA_BYTE][4:0] == srdc_pkg::SA_DEVID);
		// extent bit is left undecoded; the initiator keeps it clear
		thirdParty = cdb[srdc_pkg::REL_FLAG_BYTE][srdc_pkg::REL_THIRD_BIT];
		capField   = {cdb[srdc_pkg::CAP_FIRST_BYTE], cdb[srdc_pkg::CAP_FIRST_BYTE+1],
			cdb[srdc_pkg::CAP_FIRST_BYTE+2], cdb[srdc_pkg::CAP_FIRST_BYTE+3],
			cdb[srdc_pkg::CAP_FIRST_BYTE+4], cdb[srdc_pkg::CAP_FIRST_BYTE+5],
			cdb[srdc_pkg::CAP_FIRST_BYTE+6], cdb[srdc_pkg::CAP_FIRST_BYTE+7]};
		elemField  = {cdb[srdc_pkg::ELEM_FIRST_BYTE], cdb[srdc_pkg::ELEM_FIRST_BYTE+1],
			cdb[srdc_pkg::ELEM_FIRST_BYTE+2], cdb[srdc_pkg::ELEM_FIRST_BYTE+3]};
	end

	// ****************************************
	// command sequencing
	// ****************************************
	always_comb begin
		next_r         = r;
		next_r.relReq  = 1'b0;
		next_r.dpStart = 1'b0;
		cmdReady       = (r.fsm == srdc_pkg::ST_IDLE);

		if (formatDone && formatOk)
			next_r.corrupt = 1'b0;

		case (r.fsm)
			srdc_pkg::ST_IDLE: begin
				if (cmdValid) begin
					next_r.fsm = srdc_pkg::ST_DONE;
					next_r.res = '{srdc_pkg::STATUS_GOOD, srdc_pkg::SK_NONE, srdc_pkg::ASC_NONE};
					if (mediumAccessCmd && r.corrupt) begin
						next_r.res = '{srdc_pkg::STATUS_CHECK, srdc_pkg::SK_MEDIUM_ERROR,
							srdc_pkg::ASC_DEPOP_FAILED};
					end else if (isRelease) begin
						// byte 2 is never looked at
						if (thirdParty) begin
							next_r.res = '{srdc_pkg::STATUS_CHECK, srdc_pkg::SK_ILLEGAL_REQ,
								srdc_pkg::ASC_INVALID_CDB};
						end else begin
							// good either way; the store keeps another owner's hold
							next_r.relReq = !reservedByOther;
						end
					end else if (isDepop) begin
						next_r.cap  = capField;
						next_r.elem = ELEM_ID_W'(elemField);
						if (ucodeDeferred) begin
							next_r.res = '{srdc_pkg::STATUS_CHECK, srdc_pkg::SK_NOT_READY,
								srdc_pkg::ASC_UCODE_ACT};
						end else if (!elemSupported ||
							elemPhysType != srdc_pkg::STORAGE_ELEM_TYPE) begin
							next_r.res = '{srdc_pkg::STATUS_CHECK, srdc_pkg::SK_ILLEGAL_REQ,
								srdc_pkg::ASC_INVALID_CDB};
						end else if (!elemDepopSupported) begin
							next_r.res = '{srdc_pkg::STATUS_CHECK, srdc_pkg::SK_ILLEGAL_REQ,
								srdc_pkg::ASC_INVALID_CDB};
						end else begin
							next_r.fsm     = srdc_pkg::ST_WORK;
							next_r.dpStart = 1'b1;
						end
					end else if (isDevid) begin
						if (lunField != 16'h0000) begin
							next_r.res = '{srdc_pkg::STATUS_CHECK, srdc_pkg::SK_ILLEGAL_REQ,
								srdc_pkg::ASC_INVALID_CDB};
						end else if (!nvReady) begin
							next_r.res = '{srdc_pkg::STATUS_CHECK, srdc_pkg::SK_NOT_READY,
								nvAsc};
						end else begin
							// shorter of allocation and full data; no error when cut
							next_r.xferLen = (allocLen < fullLen) ? allocLen : fullLen;
							next_r.idx     = 32'h0000_0000;
							if (allocLen != 32'h0000_0000 && fullLen != 32'h0000_0000) begin
								next_r.fsm    = srdc_pkg::ST_DATA;
								next_r.dValid = 1'b1;
								next_r.dByte  = replyByte(32'h0000_0000);
								next_r.dLast  = (next_r.xferLen == 32'h0000_0001);
							end
						end
					end else begin
						next_r.res = '{srdc_pkg::STATUS_CHECK, srdc_pkg::SK_ILLEGAL_REQ,
							srdc_pkg::ASC_INVALID_CDB};
					end
				end
			end

			srdc_pkg::ST_WORK: begin
				if (depopDone) begin
					next_r.fsm = srdc_pkg::ST_DONE;
					if (depopCapUnsettable) begin
						// engine reports it left capacity alone
						next_r.res = '{srdc_pkg::STATUS_CHECK, srdc_pkg::SK_ILLEGAL_REQ,
							srdc_pkg::ASC_INVALID_CDB};
					end else if (!depopOk) begin
						next_r.corrupt = 1'b1;
						next_r.res = '{srdc_pkg::STATUS_CHECK, srdc_pkg::SK_MEDIUM_ERROR,
							srdc_pkg::ASC_DEPOP_FAILED};
					end
				end
			end

			srdc_pkg::ST_DATA: begin
				if (dataReady) begin
					if (r.dLast) begin
						next_r.dValid = 1'b0;
						next_r.dLast  = 1'b0;
						next_r.fsm    = srdc_pkg::ST_DONE;
					end else begin
						next_r.idx   = nextIdx;
						next_r.dByte = replyByte(nextIdx);
						next_r.dLast = (nextIdx + 32'h0000_0001 == r.xferLen);
					end
				end
			end

			srdc_pkg::ST_DONE: begin
				next_r.fsm = srdc_pkg::ST_IDLE;
			end
			default: begin
				next_r.fsm = srdc_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			r.fsm     <= srdc_pkg::ST_IDLE;
			r.res     <= '0;
			r.corrupt <= 1'b0;
			r.relReq  <= 1'b0;
			r.dpStart <= 1'b0;
			r.cap     <= '0;
			r.elem    <= '0;
			r.xferLen <= '0;
			r.idx     <= '0;
			r.dValid  <= 1'b0;
			r.dByte   <= '0;
			r.dLast   <= 1'b0;
		end else begin
			r <= next_r;
		end
	end

	// ****************************************
	// identifier store
	// ****************************************
	// power-up zero length; no reset term so it outlives reset
	always_ff @(posedge clk) begin
		if (setIdValid) begin
			idLength <= (setIdLength > 32'(ID_MAX_BYTES)) ? 32'(ID_MAX_BYTES) : setIdLength;
		end
	end

	// one byte cell per identifier byte; none of them sees reset or format
	genvar gb;
	generate
		for (gb = 0; gb < ID_MAX_BYTES; gb++) begin : g_idByte
			logic [7:0] idByteReg = 8'h00;

			always_ff @(posedge clk) begin
				if (setIdValid) begin
					idByteReg <= setIdValue[8*gb +: 8];
				end
			end

			assign idBytes[gb] = idByteReg;
		end
	endgenerate

	// ****************************************
	// outputs
	// ****************************************
	assign releaseReq    = r.relReq;
	assign depopStart    = r.dpStart;
	assign depopCapacity = r.cap;
	assign depopElement  = r.elem;
	assign formatCorrupt = r.corrupt;
	assign dataValid     = r.dValid;
	assign dataByte      = r.dByte;
	assign dataLast      = r.dLast;
	assign doneValid     = (r.fsm == srdc_pkg::ST_DONE);
	assign result        = r.res;

endmodule : srdc_cmds

`default_nettype wire

// ### bench/srdc_chk.sv
`timescale 1ns/10ps
`default_nettype none
module srdc_chk (
	// clock and reset
	input wire logic                   clk,
	input wire logic                   reset,
	// command side
	input wire logic                   cmdValid,
	input wire logic                   cmdReady,
	input wire srdc_pkg::srdc_cdb_t    cdb,
	input wire logic                   mediumAccessCmd,
	input wire logic                   reservedByOther,
	input wire logic                   releaseReq,
	// depopulation side
	input wire logic                   ucodeDeferred,
	input wire logic                   elemSupported,
	input wire logic                   depopStart,
	input wire logic [63:0]            depopCapacity,
	input wire logic                   depopDone,
	input wire logic                   depopCapUnsettable,
	input wire logic                   formatCorrupt,
	input wire logic [31:0]            depopElement,
	// data side
	input wire logic                   dataValid,
	input wire logic                   dataReady,
	input wire logic                   dataLast,
	// completion
	input wire logic                   doneValid,
	input wire srdc_pkg::srdc_result_s result
);
	// ****
	// helpers
	// ****
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	logic        tk;
	logic        rel;
	logic        dep;
	logic [63:0] capIn;
	logic [27:0] ill;
	assign tk    = cmdValid && cmdReady && !mediumAccessCmd;
	assign rel   = tk && cdb[0] == srdc_pkg::OP_RELEASE10;
	assign dep   = tk && cdb[0] == srdc_pkg::OP_DEPOP && cdb[1][4:0] == srdc_pkg::SA_DEPOP;
	assign capIn = {cdb[2], cdb[3], cdb[4], cdb[5], cdb[6], cdb[7], cdb[8], cdb[9]};
	assign ill   = {srdc_pkg::STATUS_CHECK, srdc_pkg::SK_ILLEGAL_REQ, srdc_pkg::ASC_INVALID_CDB};
	property p_rel_other;
		rel && reservedByOther && !cdb[1][4] |=> doneValid && !releaseReq
			&& result.status == srdc_pkg::STATUS_GOOD;
	endproperty
	a_rel_other: assert property (p_rel_other) else $error("release altered foreign hold");
	property p_rel_own;
		rel && !reservedByOther && !cdb[1][4] |=> doneValid && releaseReq
			&& result.status == srdc_pkg::STATUS_GOOD;
	endproperty
	a_rel_own: assert property (p_rel_own) else $error("own release not passed on");
	property p_elem_id;
		dep ##1 depopStart |-> depopElement == $past({cdb[10], cdb[11], cdb[12], cdb[13]});
	endproperty
	a_elem_id: assert property (p_elem_id) else $error("element field wrong");
	property p_last;
		dataValid && dataReady && dataLast |=> doneValid && !dataValid;
	endproperty
	a_last: assert property (p_last) else $error("data end not followed by status");
	property p_rel_third;
		rel && cdb[1][4] |=> doneValid && result == ill;
	endproperty
	a_rel_third: assert property (p_rel_third) else $error("third party not refused");
	property p_ucode;
		dep && ucodeDeferred |=> doneValid && !depopStart && result == {srdc_pkg::STATUS_CHECK,
			srdc_pkg::SK_NOT_READY, srdc_pkg::ASC_UCODE_ACT};
	endproperty
	a_ucode: assert property (p_ucode) else $error("microcode pending not refused");
	property p_elem;
		dep && !ucodeDeferred && !elemSupported |=> doneValid && result == ill;
	endproperty
	a_elem: assert property (p_elem) else $error("bad element not refused");
	property p_cap;
		dep ##1 depopStart |-> depopCapacity == $past(capIn);
	endproperty
	a_cap: assert property (p_cap) else $error("capacity field wrong");
	property p_unsettable;
		depopDone && depopCapUnsettable |=> doneValid && result == ill && $stable(formatCorrupt);
	endproperty
	a_unsettable: assert property (p_unsettable) else $error("capacity refusal wrong");
	property p_corrupt;
		cmdValid && cmdReady && mediumAccessCmd && formatCorrupt |=> doneValid
			&& result == {srdc_pkg::STATUS_CHECK, srdc_pkg::SK_MEDIUM_ERROR,
			srdc_pkg::ASC_DEPOP_FAILED};
	endproperty
	a_corrupt: assert property (p_corrupt) else $error("corrupt medium access passed");
	property p_one_status;
		doneValid |=> !doneValid && cmdReady;
	endproperty
	a_one_status: assert property (p_one_status) else $error("status not single");
endmodule : srdc_chk
bind srdc_cmds srdc_chk u_chk (.clk, .reset, .cmdValid, .cmdReady, .cdb, .mediumAccessCmd,
	.reservedByOther, .releaseReq, .ucodeDeferred, .elemSupported, .depopStart,
	.depopCapacity, .depopDone, .depopCapUnsettable, .formatCorrupt, .depopElement,
	.dataValid, .dataReady, .dataLast, .doneValid, .result);
`default_nettype wire

// ### bench/srdc_init_model.sv
`timescale 1ns/10ps
`default_nettype none
module srdc_init_model (
	// clock and reset
	input wire logic  clk,
	input wire logic  reset,
	// pacing and traffic
	input wire logic  slow,
	input wire logic  depopStart,
	output var logic  depopDone,
	output var logic  dataReady
);
	// ****
	// far side
	// ****
	logic [3:0] cnt;
	always_ff @(posedge clk) begin
		if (reset) begin
			cnt       <= 4'h0;
			depopDone <= 1'b0;
			dataReady <= 1'b0;
		end else begin
			// engine answers some cycles later, never in the start cycle
			depopDone <= cnt == 4'h1;
			cnt       <= depopStart ? 4'h5 : (cnt != 4'h0 ? cnt - 4'h1 : 4'h0);
			// slow reader stalls every other cycle
			dataReady <= slow ? ~dataReady : 1'b1;
		end
	end
endmodule : srdc_init_model
`default_nettype wire

// ### bench/test_srdc_cmds.sv
`timescale 1ns/10ps
`default_nettype none
module test_srdc_cmds;
	// ****
	// signals
	// ****
	typedef struct {srdc_pkg::srdc_cdb_t c; logic [6:0] f; logic [27:0] r;} srdc_row_s;
	localparam logic [27:0] GOOD = {srdc_pkg::STATUS_GOOD, srdc_pkg::SK_NONE, srdc_pkg::ASC_NONE};
	localparam logic [27:0] ILL = {srdc_pkg::STATUS_CHECK, srdc_pkg::SK_ILLEGAL_REQ,
		srdc_pkg::ASC_INVALID_CDB};
	localparam logic [27:0] ME = {srdc_pkg::STATUS_CHECK, srdc_pkg::SK_MEDIUM_ERROR,
		srdc_pkg::ASC_DEPOP_FAILED};
	localparam logic [27:0] UC = {srdc_pkg::STATUS_CHECK, srdc_pkg::SK_NOT_READY,
		srdc_pkg::ASC_UCODE_ACT};
	localparam logic [27:0] NR = {srdc_pkg::STATUS_CHECK, srdc_pkg::SK_NOT_READY, 16'h0401};
	localparam logic [95:0] DP = {64'h0000_0000_0000_0100, 32'h0000_0002};
	logic clk, reset, cmdValid, mediumAccessCmd, reservedByOther, depopOk, depopCapUnsettable;
	logic elemSupported, eT, elemDepopSupported, ucodeDeferred, formatDone, formatOk, nvReady;
	logic setIdValid, slow, cmdReady, releaseReq, depopStart, depopDone, formatCorrupt;
	logic dataValid, dataLast, dataReady, doneValid;
	logic [7:0] dataByte;
	logic [31:0] setIdLength;
	logic [511:0] setIdValue;
	srdc_pkg::srdc_cdb_t cdb;
	srdc_pkg::srdc_result_s result;
	logic [7:0] q[$];
	srdc_row_s rows[11];
	int fails, total_checks, cycles, tn;
	srdc_cmds u_dut (.clk, .reset, .cmdValid, .cmdReady, .cdb, .mediumAccessCmd,
		.reservedByOther, .releaseReq, .depopStart, .depopCapacity(), .depopElement(),
		.depopDone, .depopOk, .depopCapUnsettable, .elemSupported,
		.elemPhysType(eT ? 8'h01 : 8'h02), .elemDepopSupported, .ucodeDeferred, .formatDone,
		.formatOk, .formatCorrupt, .nvReady, .nvSenseKey(4'h2), .nvAsc(16'h0401), .setIdValid,
		.setIdLength, .setIdValue, .dataValid, .dataByte, .dataLast, .dataReady, .doneValid,
		.result);
	srdc_init_model u_ini (.clk, .reset, .slow, .depopStart, .depopDone, .dataReady);
	// ****
	// tasks
	// ****
	function automatic srdc_pkg::srdc_cdb_t mk(input logic [7:0] op, b1, input logic [95:0] r);
		mk = '0;
		mk[0] = op;
		mk[1] = b1;
		for (int i = 0; i < 12; i++) mk[2+i] = r[95-8*i -: 8];
	endfunction : mk
	function automatic srdc_pkg::srdc_cdb_t rp(input logic [31:0] a);
		rp = mk(8'hA3, 8'h05, {32'h0000_0000, a, 32'h0000_0000});
	endfunction : rp
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic run(input srdc_pkg::srdc_cdb_t c, input logic [6:0] f);
		int n;
		n = 0;
		q = {};
		cdb <= c;
		{mediumAccessCmd, reservedByOther, ucodeDeferred, elemSupported, eT,
			elemDepopSupported, nvReady} <= f;
		cmdValid <= 1'b1;
		@(posedge clk);
		while (cmdReady !== 1'b1 && n++ < 50) @(posedge clk);
		cmdValid <= 1'b0;
		do begin
			@(posedge clk);
			if (dataValid === 1'b1 && dataReady === 1'b1) q.push_back(dataByte);
		end while (doneValid !== 1'b1 && n++ < 500);
		if (n >= 500) fails++;
		$display("test %0d done", tn++);
	endtask : run
	task automatic final_report;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report
	// ****
	// stimulus
	// ****
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails++;
			final_report();
		end
	end
	initial begin
		{cmdValid, mediumAccessCmd, reservedByOther, depopOk, depopCapUnsettable, eT} = '0;
		{elemSupported, elemDepopSupported, ucodeDeferred, formatDone, formatOk} = '0;
		{nvReady, setIdValid, slow, setIdLength, setIdValue, cdb} = '0;
		{fails, total_checks, cycles, tn} = '0;
		rows = '{'{mk(8'h57, 8'h00, 0), 7'h2F, GOOD}, '{mk(8'h57, 8'h10, 0), 7'h0F, ILL},
			'{mk(8'h57, 8'h00, {8'hFF, 88'h0}), 7'h0F, GOOD}, '{mk(8'h9E, 8'h18, DP), 7'h1F, UC},
			'{mk(8'h9E, 8'h18, DP), 7'h07, ILL}, '{mk(8'h9E, 8'h18, DP), 7'h0B, ILL},
			'{mk(8'h9E, 8'h18, DP), 7'h0D, ILL}, '{mk(8'hA3, 8'h05, {32'h0000_0001, 64'h10}),
			7'h0F, ILL}, '{rp(32'h0000_0010), 7'h0E, NR}, '{rp(32'h0000_0000), 7'h0F, GOOD},
			'{mk(8'hC0, 8'h00, 0), 7'h0F, ILL}};
		reset = 1'b1;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		foreach (rows[i]) begin
			run(rows[i].c, rows[i].f);
			chk(result, rows[i].r);
			chk(q.size(), 0);
		end
		depopOk <= 1'b1;
		run(mk(8'h9E, 8'h18, DP), 7'h0F);
		chk(result, GOOD);
		depopCapUnsettable <= 1'b1;
		run(mk(8'h9E, 8'h18, DP), 7'h0F);
		chk(result, ILL);
		chk(formatCorrupt, 0);
		{depopCapUnsettable, depopOk} <= 2'b00;
		run(mk(8'h9E, 8'h18, DP), 7'h0F);
		chk(formatCorrupt, 1);
		run(mk(8'hC0, 8'h00, 0), 7'h4F);
		chk(result, ME);
		{formatDone, formatOk} <= 2'b11;
		@(posedge clk);
		formatDone <= 1'b0;
		@(posedge clk);
		chk(formatCorrupt, 0);
		run(mk(8'hC0, 8'h00, 0), 7'h4F);
		chk(result, ILL);
		run(rp(32'h0000_0008), 7'h0F);
		chk(q.size(), 4);
		chk({q[0], q[1], q[2], q[3]}, 0);
		{setIdValid, setIdLength, slow} <= {1'b1, 32'h0000_0005, 1'b1};
		setIdValue[39:0] <= 40'h55_4433_2211;
		@(posedge clk);
		setIdValid <= 1'b0;
		run(rp(32'h0000_0006), 7'h0F);
		chk(q.size(), 6);
		chk({q[0], q[1], q[2], q[3], q[4], q[5]}, 48'h0000_0005_1122);
		chk(result, GOOD);
		reset <= 1'b1;
		repeat (8) @(posedge clk);
		{reset, slow} <= 2'b00;
		run(rp(32'h0000_0040), 7'h0F);
		chk(q.size(), 9);
		chk({q[4], q[5], q[6], q[7], q[8]}, 40'h11_2233_4455);
		final_report();
	end
endmodule : test_srdc_cmds
`default_nettype wire
